/* File: core/adct_timer.sv */
`timescale 1ns/100ps
`default_nettype none
`include "adct_map.svh"

module adct_timer (
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   input  wire logic                 time_we,
   input  wire logic [7:0]           time_wdata,
   input  wire logic                 ten_bit_mode,
   input  wire logic                 start,
   output logic [7:0]                time_rdata,
   output adct_pkg::adct_analog_t    analog
);

   typedef struct packed {
      adct_pkg::adct_phase_t  phase;
      adct_pkg::adct_timing_t timing;
      logic                   ten_bit;
      logic                   done;
   } adct_state_t;

   adct_state_t state;
   adct_state_t next_state;
   logic        cnt_load;
   logic [15:0] cnt_value;
   logic        cnt_running;
   logic        cnt_expire;

   // ---------------------------------------------------------------
   // Phase lengths
   // ---------------------------------------------------------------
   function automatic logic [15:0] sample_len(input logic [2:0] f);
      sample_len = 16'(f) * 16'(`ADCT_SAMPLE_MUL) + `ADCT_SAMPLE_ADD;
   endfunction

   function automatic logic [15:0] convert_len(input logic [4:0] f, input logic ten);
      logic [15:0] bits;
      bits = ten ? `ADCT_BITS_10 : `ADCT_BITS_8;
      convert_len = `ADCT_CONVERT_MUL * bits * (16'(f) + `ADCT_CONVERT_ONE)
                    + `ADCT_CONVERT_ADD;
   endfunction

   adct_counter u_counter (
      .clk        (clk),
      .rst_n      (rst_n),
      .load       (cnt_load),
      .load_value (cnt_value),
      .running    (cnt_running),
      .expire     (cnt_expire)
   );

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   always_comb begin
      next_state      = state;
      next_state.done = 1'b0;
      cnt_load        = 1'b0;
      cnt_value       = 16'h0000;
      if (time_we) begin
         next_state.timing = adct_pkg::adct_timing_t'(time_wdata);
      end
      case (state.phase)
         adct_pkg::ADCT_IDLE: begin
            if (start) begin
               next_state.phase   = adct_pkg::ADCT_SAMPLE;
               next_state.ten_bit = ten_bit_mode;
               cnt_load           = 1'b1;
               cnt_value          = sample_len(state.timing.sample_count_field);
            end
         end
         adct_pkg::ADCT_SAMPLE: begin
            if (cnt_expire) begin
               next_state.phase = adct_pkg::ADCT_CONVERT;
               cnt_load         = 1'b1;
               cnt_value        = convert_len(state.timing.convert_count_field,
                                              state.ten_bit);
            end
         end
         adct_pkg::ADCT_CONVERT: begin
            if (cnt_expire) begin
               next_state.phase = adct_pkg::ADCT_IDLE;
               next_state.done  = 1'b1;
            end
         end
         default: begin
            next_state.phase = adct_pkg::ADCT_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state.phase   <= adct_pkg::ADCT_IDLE;
         state.timing  <= adct_pkg::adct_timing_t'(`ADCT_TIME_RESET);
         state.ten_bit <= 1'b0;
         state.done    <= 1'b0;
      end else begin
         state <= next_state;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign time_rdata          = state.timing;
   assign analog.sample_switch = (state.phase == adct_pkg::ADCT_SAMPLE);
   assign analog.compare_step  = (state.phase == adct_pkg::ADCT_CONVERT);
   assign analog.busy          = (state.phase != adct_pkg::ADCT_IDLE);
   assign analog.done          = state.done;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   logic [15:0] ph_len;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ph_len <= 16'h0000;
      end else if (cnt_load) begin
         ph_len <= 16'h0001;
      end else begin
         ph_len <= ph_len + 16'h0001;
      end
   end

   a_sample_length: assert property (@(posedge clk) disable iff (!rst_n)
      (analog.sample_switch && cnt_expire) |->
      ph_len == sample_len(state.timing.sample_count_field))
      else $error("Sample phase length wrong");

   a_convert_length: assert property (@(posedge clk) disable iff (!rst_n)
      (analog.compare_step && cnt_expire) |->
      ph_len == convert_len(state.timing.convert_count_field, state.ten_bit))
      else $error("Conversion phase length wrong");

   a_phase_order: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(analog.sample_switch) |-> analog.compare_step)
      else $error("Conversion did not follow sampling");

   a_switch_exclusive: assert property (@(posedge clk) disable iff (!rst_n)
      !(analog.sample_switch && analog.compare_step))
      else $error("Sample and convert overlap");

   a_done_after_convert_count_field: assert property (@(posedge clk) disable iff (!rst_n)
      analog.done |-> $past(analog.compare_step) && !analog.busy)
      else $error("Done without conversion");

   a_start_samples: assert property (@(posedge clk) disable iff (!rst_n)
      (!analog.busy && start) |=> analog.sample_switch[*2])
      else $error("Start did not begin sampling");

   a_mode_held: assert property (@(posedge clk) disable iff (!rst_n)
      (analog.busy && $past(analog.busy)) |-> $stable(state.ten_bit))
      else $error("Bit mode changed mid conversion");

   a_field_layout: assert property (@(posedge clk) disable iff (!rst_n)
      time_we |=> state.timing.sample_count_field ==
      $past(time_wdata[`ADCT_SAMPLE_HI:`ADCT_SAMPLE_LO]))
      else $error("Timing register layout wrong");

   a_convert_field: assert property (@(posedge clk) disable iff (!rst_n)
      time_we |=> state.timing.convert_count_field ==
      $past(time_wdata[`ADCT_CONVERT_HI:`ADCT_CONVERT_LO]))
      else $error("Conversion field layout wrong");

   a_mode_latched: assert property (@(posedge clk) disable iff (!rst_n)
      (!analog.busy && start) |=> state.ten_bit == $past(ten_bit_mode))
      else $error("Bit mode not taken at start");

   a_done_single: assert property (@(posedge clk) disable iff (!rst_n)
      analog.done |=> !analog.done)
      else $error("Done longer than one cycle");

   a_convert_entry: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(analog.compare_step) |-> $past(analog.sample_switch))
      else $error("Conversion without sampling");

   a_sample_holds: assert property (@(posedge clk) disable iff (!rst_n)
      (analog.sample_switch && !cnt_expire) |=> analog.sample_switch)
      else $error("Sample phase cut short");

   a_convert_holds: assert property (@(posedge clk) disable iff (!rst_n)
      (analog.compare_step && !cnt_expire) |=> analog.compare_step)
      else $error("Conversion phase cut short");

   a_busy_counting: assert property (@(posedge clk) disable iff (!rst_n)
      analog.busy == cnt_running)
      else $error("Phase active without period count");

   // ---------------------------------------------------------------
   // Coverage
   // ---------------------------------------------------------------
   c_ten_bit: cover property (@(posedge clk) disable iff (!rst_n)
      analog.done && state.ten_bit);
   c_eight_bit: cover property (@(posedge clk) disable iff (!rst_n)
      analog.done && !state.ten_bit);
   c_write_idle: cover property (@(posedge clk) disable iff (!rst_n)
      time_we && !analog.busy);
   c_back_to_back: cover property (@(posedge clk) disable iff (!rst_n)
      analog.done && start);
   c_start_busy: cover property (@(posedge clk) disable iff (!rst_n)
      analog.busy && start);

endmodule

`default_nettype wire

/* File: core/adct_map.svh */
`ifndef ADCT_MAP_SVH
`define ADCT_MAP_SVH

// Timing register layout
`define ADCT_SAMPLE_HI   7
`define ADCT_SAMPLE_LO   5
`define ADCT_CONVERT_HI  4
`define ADCT_CONVERT_LO  0
`define ADCT_TIME_RESET  8'h00

// Phase arithmetic
`define ADCT_SAMPLE_MUL  4'd8
`define ADCT_SAMPLE_ADD  16'd2
`define ADCT_CONVERT_MUL 16'd2
`define ADCT_CONVERT_ONE 16'd1
`define ADCT_CONVERT_ADD 16'd3
`define ADCT_BITS_8      16'd8
`define ADCT_BITS_10     16'd10

`endif

/* File: core/adct_pkg.sv */
`default_nettype none

package adct_pkg;

   typedef enum logic [1:0] {
      ADCT_IDLE,
      ADCT_SAMPLE,
      ADCT_CONVERT
   } adct_phase_t;

   typedef struct packed {
      logic [2:0] sample_count_field;
      logic [4:0] convert_count_field;
   } adct_timing_t;

   typedef struct packed {
      logic sample_switch;
      logic compare_step;
      logic busy;
      logic done;
   } adct_analog_t;

endpackage

`default_nettype wire

/* File: core/adct_counter.sv */
`timescale 1ns/100ps
`default_nettype none

// Down counter of oscillator periods; expire marks the last period
module adct_counter (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        load,
   input  wire logic [15:0] load_value,
   output logic             running,
   output logic             expire
);

   typedef struct packed {
      logic [15:0] count;
      logic        run;
   } adct_cnt_state_t;

   adct_cnt_state_t state;
   adct_cnt_state_t next_state;

   always_comb begin
      next_state = state;
      if (load) begin
         next_state.count = load_value;
         next_state.run   = (load_value != 16'h0000);
      end else if (state.run) begin
         next_state.count = state.count - 16'h0001;
         if (state.count == 16'h0001) begin
            next_state.run = 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign running = state.run;
   // Load is not fed back here: the sequencer loads on a sample-phase expire
   assign expire  = state.run && (state.count == 16'h0001);

endmodule

`default_nettype wire

/* File: tb/adct_analog_model.sv */
`timescale 1ns/100ps
`default_nettype none

// Capacitor and comparator; measures each phase in clock periods
module adct_analog_model (
   input  wire logic                   clk,
   input  wire logic                   rst_n,
   input  wire adct_pkg::adct_analog_t analog,
   output logic [15:0]                 sample_len,
   output logic [15:0]                 convert_len,
   output logic                        overlap
);
   logic [15:0] s_cnt;
   logic [15:0] c_cnt;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_cnt <= 16'h0000;
         c_cnt <= 16'h0000;
         sample_len <= 16'h0000;
         convert_len <= 16'h0000;
         overlap <= 1'b0;
      end else begin
         if (analog.sample_switch) begin
            s_cnt <= s_cnt + 16'h0001;
         end else if (s_cnt != 16'h0000) begin
            sample_len <= s_cnt;
            s_cnt <= 16'h0000;
         end
         if (analog.compare_step) begin
            c_cnt <= c_cnt + 16'h0001;
         end else if (c_cnt != 16'h0000) begin
            convert_len <= c_cnt;
            c_cnt <= 16'h0000;
         end
         if (analog.sample_switch && analog.compare_step) overlap <= 1'b1;
      end
   end
endmodule

`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/100ps
`default_nettype none

module tb;
   logic                   clk = 1'b0;
   logic                   rst_n = 1'b0;
   logic                   time_we = 1'b0;
   logic [7:0]             time_wdata = 8'h00;
   logic                   ten_bit_mode = 1'b0;
   logic                   start = 1'b0;
   logic [7:0]             time_rdata;
   adct_pkg::adct_analog_t analog;
   logic [15:0]            sample_len;
   logic [15:0]            convert_len;
   logic                   overlap;
   int                     bad_count = 0;
   int                     num_checks = 0;

   always #20 clk = ~clk;

   adct_timer i_adct_timer (.clk(clk), .rst_n(rst_n), .time_we(time_we),
      .time_wdata(time_wdata), .ten_bit_mode(ten_bit_mode), .start(start),
      .time_rdata(time_rdata), .analog(analog));
   adct_analog_model i_adct_analog_model (.clk(clk), .rst_n(rst_n), .analog(analog),
      .sample_len(sample_len), .convert_len(convert_len), .overlap(overlap));

   function automatic logic [15:0] blen(input logic ten);
      return ten ? 16'd10 : 16'd8;
   endfunction

   task automatic tick;
      @(posedge clk);
      #1;
   endtask

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // Only called while idle, fields kept in range
   task automatic write_time(input logic [2:0] s, input logic [4:0] c);
      time_we = 1'b1;
      time_wdata = {s, c};
      tick;
      time_we = 1'b0;
      check("rdata", {8'h00, time_rdata}, {8'h00, s, c});
   endtask

   // Start, optionally retrigger while busy, count edges to done
   task automatic go(input logic [2:0] s, input logic [4:0] c, input logic ten, input logic poke);
      logic [15:0] n;
      n = 16'd0;
      ten_bit_mode = ten;
      start = 1'b1;
      tick;
      check("busy sampling", {14'd0, analog.busy, analog.sample_switch}, 16'd3);
      start = poke;
      ten_bit_mode = ~ten;
      while (analog.done !== 1'b1 && n < 16'd2000) begin
         tick;
         if (n == 16'd0) start = 1'b0;
         n++;
      end
      check("total", n, 16'd8 * s + 16'd5 + 16'd2 * blen(ten) * (c + 16'd1));
      check("idle at done", {15'd0, analog.busy}, 16'd0);
   endtask

   task automatic settle(input logic [2:0] s, input logic [4:0] c, input logic ten);
      tick;
      check("done width", {15'd0, analog.done}, 16'd0);
      check("sample_len", sample_len, 16'd8 * s + 16'd2);
      check("convert_len", convert_len, 16'd2 * blen(ten) * (c + 16'd1) + 16'd3);
   endtask

   task automatic test_reset;
      tick;
      check("rdata at reset", {8'h00, time_rdata}, 16'h0000);
      check("analog at reset", {12'h000, analog}, 16'h0000);
      tick;
      rst_n = 1'b1;
      write_time(3'h7, 5'h05);
      check("rdata", {8'h00, time_rdata}, 16'h00e5);
      $display("test reset and fields done");
   endtask

   task automatic test_ranges;
      for (int i = 0; i < 8; i++) begin
         write_time(i[2] ? 3'h7 : 3'h1, i[1] ? 5'h1f : 5'h02);
         go(i[2] ? 3'h7 : 3'h1, i[1] ? 5'h1f : 5'h02, i[0], 1'b0);
         settle(i[2] ? 3'h7 : 3'h1, i[1] ? 5'h1f : 5'h02, i[0]);
      end
      $display("test ranges done");
   endtask

   task automatic test_busy_start;
      write_time(3'h1, 5'h02);
      go(3'h1, 5'h02, 1'b1, 1'b1);
      settle(3'h1, 5'h02, 1'b1);
      $display("test busy start done");
   endtask

   task automatic test_back_to_back;
      write_time(3'h2, 5'h03);
      go(3'h2, 5'h03, 1'b0, 1'b0);
      go(3'h2, 5'h03, 1'b1, 1'b0);
      settle(3'h2, 5'h03, 1'b1);
      check("overlap", {15'd0, overlap}, 16'd0);
      $display("test back to back done");
   endtask

   // Counts meeting the sample and conversion time windows at 40 ns
   task automatic test_typical;
      logic [15:0] ns;
      logic [15:0] lo;
      for (int m = 0; m < 2; m++) begin
         write_time(3'h3, 5'h0c);
         go(3'h3, 5'h0c, m[0], 1'b0);
         settle(3'h3, 5'h0c, m[0]);
         ns = sample_len * 16'd40;
         check("sample time", {15'd0, ns >= 16'd1000}, 16'd1);
         ns = convert_len * 16'd40;
         lo = m[0] ? 16'd10000 : 16'd7000;
         check("convert time", {15'd0, ns >= lo && ns <= 16'd20000}, 16'd1);
      end
      $display("test typical counts done");
   endtask

   // Reset in the middle of a sample phase, then a clean conversion
   task automatic test_mid_reset;
      write_time(3'h2, 5'h03);
      start = 1'b1;
      tick;
      start = 1'b0;
      repeat (4) tick;
      rst_n = 1'b0;
      tick;
      check("analog in reset", {12'h000, analog}, 16'h0000);
      check("rdata in reset", {8'h00, time_rdata}, 16'h0000);
      rst_n = 1'b1;
      write_time(3'h2, 5'h03);
      go(3'h2, 5'h03, 1'b0, 1'b0);
      settle(3'h2, 5'h03, 1'b0);
      $display("test mid reset done");
   endtask

   initial begin
      test_reset;
      test_ranges;
      test_busy_start;
      test_back_to_back;
      test_typical;
      test_mid_reset;
      give_verdict;
   end

   initial begin
      #800000;
      bad_count++;
      give_verdict;
   end
endmodule

`default_nettype wire
